// *** logic/isf_pkg.sv ***
// Purpose: shared constants and types of the serial bus status flag block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: status bit positions follow the flag register layout
package isf_pkg;

  // register byte offsets
  localparam logic [11:0] ISF_OFF_STATUS = 12'h000;
  localparam logic [11:0] ISF_OFF_RXHOLD = 12'h004;
  localparam logic [11:0] ISF_OFF_TXHOLD = 12'h008;
  localparam logic [11:0] ISF_OFF_CTRL = 12'h00c;
  localparam logic [11:0] ISF_OFF_IRQ_STAT = 12'h010;
  localparam logic [11:0] ISF_OFF_IRQ_MASK = 12'h014;

  // serial_bus_status fields
  localparam int ISF_BIT_STOP = 4;
  localparam int ISF_BIT_START = 3;
  localparam int ISF_BIT_RW = 2;
  localparam int ISF_BIT_RXFULL = 1;
  localparam int ISF_BIT_TXFULL = 0;

  // control fields
  localparam int ISF_CTRL_EN = 0;
  localparam int ISF_CTRL_ADDR_LSB = 8;
  localparam int ISF_ADDR_W = 7;

  // interrupt event bits
  localparam int ISF_IRQ_START = 0;
  localparam int ISF_IRQ_STOP = 1;
  localparam int ISF_IRQ_RX = 2;
  localparam int ISF_IRQ_TXDONE = 3;
  localparam int ISF_IRQ_MATCH = 4;
  localparam int ISF_NUM_IRQ = 5;

  // values after reset, and the index of the last bit of a byte
  localparam logic ISF_EN_RST = 1'b0;
  localparam logic [6:0] ISF_OWN_ADDR_RST = 7'h00;
  localparam logic [4:0] ISF_MASK_RST = 5'h00;
  localparam logic [7:0] ISF_BYTE_RST = 8'h00;
  localparam logic [2:0] ISF_LAST_BIT = 3'h7;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } isf_apb_req_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } isf_link_ev_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_RX_ACK = 3'b100,
    ST_TX = 3'b101,
    ST_TX_ACK = 3'b110
  } isf_state_t;

endpackage : isf_pkg

// *** logic/isf_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module isf_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // idle bus is high, so reset to ones to avoid a false start
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : isf_sync
`default_nettype wire

// *** logic/isf_link_mon.sv ***
// Purpose: finds clock edges and start / stop conditions on the two-wire bus
// Assumes: scl and sda already synchronised to clk
// Notes: events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module isf_link_mon
  import isf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_s,
  input wire logic sda_s,
  output isf_link_ev_t ev
);
  logic scl_p_q;
  logic sda_p_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // sda moving while scl stays high marks a bus condition
  assign ev.start = ce & scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign ev.stop = ce & scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign ev.rise = ce & scl_s & ~scl_p_q;
  assign ev.fall = ce & ~scl_s & scl_p_q;
  assign ev.sda = sda_s;
endmodule : isf_link_mon
`default_nettype wire

// *** logic/isf_status_top.sv ***
// Purpose: two-wire bus slave port with its status flag register over apb
// Assumes: link clock well below clk/4; no clock stretching
// Notes: registers at byte offsets 0x00..0x14; unmapped access gives pslverr
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module isf_status_top
  import isf_pkg::*;
(
  // clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // two-wire bus pins
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // interrupt
  output logic O_IRQ
);

  function automatic logic isf_hit(input logic [11:0] addr, input logic [11:0] off);
    isf_hit = (addr[11:2] == off[11:2]);
  endfunction : isf_hit

  isf_apb_req_t req;
  isf_link_ev_t lk;
  logic [1:0] pins_s;

  assign req.psel = I_PSEL;
  assign req.penable = I_PENABLE;
  assign req.pwrite = I_PWRITE;
  assign req.paddr = I_PADDR;
  assign req.pwdata = I_PWDATA;

  isf_sync #(
    .W(2)
  ) u_sync (
    .clk(I_CLK),
    .rst(I_SYS_RST),
    .ce(I_CE),
    .d({I_SCL, I_SDA}),
    .q(pins_s)
  );

  isf_link_mon u_mon (
    .clk(I_CLK),
    .rst(I_SYS_RST),
    .ce(I_CE),
    .scl_s(pins_s[1]),
    .sda_s(pins_s[0]),
    .ev(lk)
  );

  // state
  isf_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic oe_q, oe_d;
  logic rw_q, rw_d;
  logic seen_q, seen_d;
  logic ack_q, ack_d;
  logic nack_q, nack_d;
  logic [7:0] rxh_q, rxh_d;
  logic [7:0] txh_q;
  logic rxf_q, txf_q;
  logic start_q, stop_q;
  logic en_q;
  logic [6:0] own_q;
  logic [ISF_NUM_IRQ-1:0] irq_q, mask_q, ev_w;
  logic pready_q, pslverr_q, irq_out_q, sda_o_q;
  logic [31:0] prdata_q;
  logic rx_wr, ev_txdone, ev_match, ev_rx;

  // apb decode: first access cycle computes the answer, second completes
  logic acc_first, acc_done, wr_done, rd_done;
  logic sel_stat, sel_rx, sel_tx, sel_ctrl, sel_istat, sel_imask, mapped;
  logic [31:0] stat_w, rd_mux;

  assign acc_first = req.psel & req.penable & ~pready_q;
  assign acc_done = req.psel & req.penable & pready_q;
  assign wr_done = acc_done & req.pwrite;
  assign rd_done = acc_done & ~req.pwrite;
  assign sel_stat = isf_hit(req.paddr, ISF_OFF_STATUS);
  assign sel_rx = isf_hit(req.paddr, ISF_OFF_RXHOLD);
  assign sel_tx = isf_hit(req.paddr, ISF_OFF_TXHOLD);
  assign sel_ctrl = isf_hit(req.paddr, ISF_OFF_CTRL);
  assign sel_istat = isf_hit(req.paddr, ISF_OFF_IRQ_STAT);
  assign sel_imask = isf_hit(req.paddr, ISF_OFF_IRQ_MASK);
  assign mapped = sel_stat | sel_rx | sel_tx | sel_ctrl | sel_istat | sel_imask;

  always_comb begin
    stat_w = '0;
    stat_w[ISF_BIT_STOP] = stop_q;
    stat_w[ISF_BIT_START] = start_q;
    stat_w[ISF_BIT_RW] = rw_q;
    stat_w[ISF_BIT_RXFULL] = rxf_q;
    stat_w[ISF_BIT_TXFULL] = txf_q;
  end

  assign rd_mux = sel_stat ? stat_w :
                  sel_rx ? {24'h000000, rxh_q} :
                  sel_tx ? {24'h000000, txh_q} :
                  sel_ctrl ? {16'h0000, 1'b0, own_q, 7'h00, en_q} :
                  sel_istat ? {27'h0000000, irq_q} :
                  sel_imask ? {27'h0000000, mask_q} : 32'h00000000;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (I_CE) begin
      pready_q <= acc_first;
      pslverr_q <= acc_first & ~mapped;
      if (acc_first && !req.pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // control, mask and transmit holding writes; status word has no write path
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      en_q <= ISF_EN_RST;
      own_q <= ISF_OWN_ADDR_RST;
      mask_q <= ISF_MASK_RST;
      txh_q <= ISF_BYTE_RST;
    end else if (I_CE && wr_done) begin
      if (sel_ctrl) begin
        en_q <= req.pwdata[ISF_CTRL_EN];
        own_q <= req.pwdata[ISF_CTRL_ADDR_LSB +: ISF_ADDR_W];
      end
      if (sel_imask) begin
        mask_q <= req.pwdata[ISF_NUM_IRQ-1:0];
      end
      if (sel_tx) begin
        txh_q <= req.pwdata[7:0];
      end
    end
  end

  // link state machine; bits sampled on scl rise, sda changed on scl fall
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    oe_d = oe_q;
    rw_d = rw_q;
    seen_d = seen_q;
    ack_d = ack_q;
    nack_d = nack_q;
    rxh_d = rxh_q;
    rx_wr = 1'b0;
    ev_txdone = 1'b0;
    ev_match = 1'b0;
    ev_rx = 1'b0;
    if (lk.start) begin
      st_d = ST_ADDR;
      cnt_d = 3'h0;
      oe_d = 1'b0;
    end else if (lk.stop || !en_q) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        ST_ADDR: begin
          if (lk.rise) begin
            sh_d = {sh_q[6:0], lk.sda};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == ISF_LAST_BIT) begin
              // only a matching address claims the transfer
              if (sh_q[6:0] == own_q) begin
                rw_d = lk.sda;
                ev_match = 1'b1;
                seen_d = 1'b0;
                nack_d = 1'b0;
                st_d = ST_ADDR_ACK;
              end else begin
                st_d = ST_IDLE;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          if (lk.fall) begin
            if (!seen_q) begin
              oe_d = ~nack_q;
              seen_d = 1'b1;
            end else begin
              oe_d = 1'b0;
              seen_d = 1'b0;
              cnt_d = 3'h0;
              if (st_q == ST_ADDR_ACK && rw_q) begin
                st_d = ST_TX;
                sh_d = txh_q;
                oe_d = ~txh_q[7];
              end else begin
                st_d = ST_RX;
              end
            end
          end
        end
        ST_RX: begin
          if (lk.rise) begin
            sh_d = {sh_q[6:0], lk.sda};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == ISF_LAST_BIT) begin
              // a full holding register drops the byte and answers nack
              st_d = ST_RX_ACK;
              seen_d = 1'b0;
              nack_d = rxf_q;
              if (!rxf_q) begin
                rxh_d = {sh_q[6:0], lk.sda};
                rx_wr = 1'b1;
                ev_rx = 1'b1;
              end
            end
          end
        end
        ST_TX: begin
          if (lk.rise) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == ISF_LAST_BIT) begin
              st_d = ST_TX_ACK;
              seen_d = 1'b0;
              ev_txdone = 1'b1;
            end
          end else if (lk.fall) begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_q[6];
          end
        end
        ST_TX_ACK: begin
          if (lk.rise) begin
            ack_d = ~lk.sda;
            seen_d = 1'b1;
          end else if (lk.fall) begin
            oe_d = 1'b0;
            if (seen_q) begin
              seen_d = 1'b0;
              cnt_d = 3'h0;
              if (ack_q) begin
                st_d = ST_TX;
                sh_d = txh_q;
                oe_d = ~txh_q[7];
              end else begin
                st_d = ST_IDLE;
              end
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      sh_q <= ISF_BYTE_RST;
      oe_q <= 1'b0;
      rw_q <= 1'b0;
      seen_q <= 1'b0;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      rxh_q <= ISF_BYTE_RST;
    end else if (I_CE) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      oe_q <= oe_d;
      rw_q <= rw_d;
      seen_q <= seen_d;
      ack_q <= ack_d;
      nack_q <= nack_d;
      rxh_q <= rxh_d;
    end
  end

  // bus condition flags: last condition seen wins
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (I_CE) begin
      if (lk.start) begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
      end else if (lk.stop) begin
        stop_q <= 1'b1;
        start_q <= 1'b0;
      end
    end
  end

  // holding flags: rx full set by hardware, tx full set by a write; either set beats a same-cycle clear
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rxf_q <= 1'b0;
      txf_q <= 1'b0;
    end else if (I_CE) begin
      rxf_q <= (rxf_q & ~(rd_done & sel_rx)) | rx_wr;
      txf_q <= (txf_q & ~ev_txdone) | (wr_done & sel_tx);
    end
  end

  // sticky events, write one to clear; new event wins
  always_comb begin
    ev_w = '0;
    ev_w[ISF_IRQ_START] = lk.start;
    ev_w[ISF_IRQ_STOP] = lk.stop;
    ev_w[ISF_IRQ_RX] = ev_rx;
    ev_w[ISF_IRQ_TXDONE] = ev_txdone;
    ev_w[ISF_IRQ_MATCH] = ev_match;
  end

  logic [ISF_NUM_IRQ-1:0] irq_clr;
  assign irq_clr = (wr_done & sel_istat) ? req.pwdata[ISF_NUM_IRQ-1:0] : '0;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      irq_q <= '0;
      irq_out_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else if (I_CE) begin
      irq_q <= (irq_q & ~irq_clr) | ev_w;
      irq_out_q <= |(irq_q & mask_q);
      sda_o_q <= 1'b0;
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_SDA = sda_o_q;
  assign O_SDA_OE = oe_q;
  assign O_IRQ = irq_out_q;

endmodule : isf_status_top
`default_nettype wire

// *** sim/isf_status_checker.sv ***
// Purpose: port checks of the status flag block
// Assumes: I_CE held high
// Notes: rx and tx flag checks wait for a quiet link
`timescale 1ns/1ps
`default_nettype none
module isf_status_checker
  import isf_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_SCL,
  input wire logic I_SDA
);
  logic [2:0] quiet_q;
  logic rx_rd_q;
  logic tx_wr_q;
  wire done = I_PSEL && I_PENABLE && O_PREADY;
  wire [9:0] idx = I_PADDR[11:2];
  wire idle = quiet_q == 3'h7;
  wire rd_st = done && !I_PWRITE && idx == 10'h0;
  // pin to flag takes at most 4 clk, so 7 quiet clk is settled
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || $changed(I_SCL) || $changed(I_SDA)) begin
      quiet_q <= 3'h0;
    end else if (!idle) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end
  always_ff @(posedge I_CLK) begin
    rx_rd_q <= idle && !I_SYS_RST && (rx_rd_q || (done && !I_PWRITE && idx == 10'h1));
    tx_wr_q <= idle && !I_SYS_RST && (tx_wr_q || (done && I_PWRITE && idx == 10'h2));
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_first; I_PSEL && I_PENABLE && !O_PREADY; endsequence
  sequence s_answer; O_PREADY ##1 !O_PREADY; endsequence
  property p_wait; s_first |=> s_answer; endproperty
  property p_stray; O_PREADY |-> I_PSEL && I_PENABLE && $past(I_PENABLE); endproperty
  property p_err; done |-> O_PSLVERR == (idx > 10'h5); endproperty
  property p_err_data; done && O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0; endproperty
  property p_rd_hold; done && !I_PWRITE |=> $stable(O_PRDATA); endproperty
  property p_excl; rd_st |-> !(O_PRDATA[ISF_BIT_STOP] && O_PRDATA[ISF_BIT_START]); endproperty
  property p_rx_clr; rd_st && rx_rd_q |-> !O_PRDATA[ISF_BIT_RXFULL]; endproperty
  property p_tx_set; rd_st && tx_wr_q |-> O_PRDATA[ISF_BIT_TXFULL]; endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  a_stray: assert property (p_stray) else $error("stray ready");
  a_err: assert property (p_err) else $error("wrong error flag");
  a_err_data: assert property (p_err_data) else $error("error data not zero");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_excl: assert property (p_excl) else $error("start and stop both set");
  a_rx_clr: assert property (p_rx_clr) else $error("rx full after read");
  a_tx_set: assert property (p_tx_set) else $error("tx full not set");
endmodule : isf_status_checker
bind isf_status_top isf_status_checker chk_u (
  .I_CLK, .I_SYS_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
  .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_SCL, .I_SDA
);
`default_nettype wire

// *** sim/isf_i2c_master_model.sv ***
// Purpose: behavioural two-wire bus master
// Assumes: 2 clk a quarter bit, a 200 ns link clock
// Notes: scl rests high between frames; no stretching
`timescale 1ns/1ps
`default_nettype none
module isf_i2c_master_model (
  // clock and wire
  input wire logic i_clk,
  input wire logic i_sda,
  // driven lines
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic q();
    repeat (2) @(posedge i_clk);
  endtask : q
  // a=1 b=0 gives a start ending scl low, a=0 b=1 a stop
  task automatic cond(input logic a, input logic b);
    o_sda <= a;
    q();
    o_scl <= 1'b1;
    q();
    o_sda <= b;
    q();
    o_scl <= b;
    q();
  endtask : cond
  task automatic bit_x(input logic b, output logic r);
    o_sda <= b;
    q();
    o_scl <= 1'b1;
    q();
    r = i_sda;
    q();
    o_scl <= 1'b0;
    q();
  endtask : bit_x
  // msb first, then the ack slot; a 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                      output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(a, k);
  endtask : xfer
endmodule : isf_i2c_master_model
`default_nettype wire

// *** sim/i2c_status_flag_logic_tb_top.sv ***
// Purpose: register level regression of the status flag block
// Assumes: partner master on the pins, checker bound to the top
// Notes: the link rests while status is read
`timescale 1ns/1ps
`default_nettype none
module i2c_status_flag_logic_tb_top
  import isf_pkg::*;
;
  localparam logic [6:0] ADR = 7'h2a;
  logic clk, rst, pready, pslverr, scl, sda_m, sda_o, sda_oe, irq, err, ack;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic [7:0] rb;
  isf_apb_req_t req;
  int failures = 0;
  int n_compared = 0;
  // open drain line with pull-up
  wire sda_w = (sda_oe ? sda_o : 1'b1) & sda_m;
  isf_status_top dut_u (
    .I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1),
    .I_PSEL(req.psel), .I_PENABLE(req.penable), .I_PWRITE(req.pwrite),
    .I_PADDR(req.paddr), .I_PWDATA(req.pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SCL(scl), .I_SDA(sda_w), .O_SDA(sda_o), .O_SDA_OE(sda_oe), .O_IRQ(irq)
  );
  isf_i2c_master_model m_u (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_m));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] s);
    n_compared++;
    if (s !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, x, s);
    end
  endtask : chk
  // request held until ready is sampled, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    // no fixed wait assumed; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    req <= '0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, rdat);
  endtask : rd
  task automatic st(input logic [31:0] x);
    rd(ISF_OFF_STATUS, x);
  endtask : st
  initial begin
    rst = 1'b1;
    req = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    st(32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, ISF_OFF_STATUS, 32'h1f);
    st(32'h0);
    apb(1'b1, ISF_OFF_CTRL, {17'h0, ADR, 8'h01});
    apb(1'b1, ISF_OFF_IRQ_MASK, 32'h1f);
    m_u.cond(1'b1, 1'b0);
    st(32'h08);
    m_u.xfer({ADR, 1'b0}, 1'b1, rb, ack);
    chk("addr ack", 32'h0, {31'h0, ack});
    m_u.xfer(8'h5a, 1'b1, rb, ack);
    chk("data ack", 32'h0, {31'h0, ack});
    st(32'h0a);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, ISF_OFF_STATUS, 32'h0);
    st(32'h0a);
    rd(ISF_OFF_RXHOLD, 32'h5a);
    st(32'h08);
    rd(ISF_OFF_IRQ_STAT, 32'h15);
    apb(1'b1, ISF_OFF_IRQ_STAT, 32'h1f);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    m_u.cond(1'b0, 1'b1);
    st(32'h10);
    apb(1'b1, ISF_OFF_TXHOLD, 32'hc3);
    st(32'h11);
    m_u.cond(1'b1, 1'b0);
    m_u.xfer({ADR, 1'b1}, 1'b1, rb, ack);
    st(32'h0d);
    m_u.xfer(8'hff, 1'b1, rb, ack);
    chk("sent byte", 32'hc3, {24'h0, rb});
    st(32'h0c);
    m_u.cond(1'b0, 1'b1);
    st(32'h14);
    rd(ISF_OFF_IRQ_STAT, 32'h1b);
    apb(1'b1, ISF_OFF_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    // second byte while rx is still full is refused with a nack
    m_u.cond(1'b1, 1'b0);
    m_u.xfer({ADR, 1'b0}, 1'b1, rb, ack);
    chk("addr ack", 32'h0, {31'h0, ack});
    m_u.xfer(8'h3c, 1'b1, rb, ack);
    chk("data ack", 32'h0, {31'h0, ack});
    m_u.xfer(8'h77, 1'b1, rb, ack);
    chk("full nack", 32'h1, {31'h0, ack});
    st(32'h0a);
    rd(ISF_OFF_RXHOLD, 32'h3c);
    // foreign address must leave the direction flag alone
    m_u.cond(1'b1, 1'b0);
    m_u.xfer({~ADR, 1'b1}, 1'b1, rb, ack);
    chk("other addr", 32'h1, {31'h0, ack});
    st(32'h08);
    m_u.cond(1'b0, 1'b1);
    st(32'h10);
    end_of_test();
  end
  initial begin
    #100us;
    failures++;
    $display("[FAIL] watchdog expected done seen timeout");
    end_of_test();
  end
endmodule : i2c_status_flag_logic_tb_top
`default_nettype wire
